/* bus_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// far side: pin levels seen on the board, host wait programming
// ---------------------------------------------------------------
module bus_side_model
	import periph_pin_pkg::*;
#(
	parameter logic [WAIT_W-1:0] DRAM_WAIT = 4'h2
) (
	input  wire logic                    clk_sys,
	input  wire logic [SELECT_COUNT-1:0] selectN_out,
	input  wire logic [SELECT_COUNT-1:0] selectN_oe,
	input  wire logic [SELECT_COUNT-1:0] selectWeakPull,
	input  wire logic                    readN_out,
	input  wire logic                    readN_oe,
	output logic      [SELECT_COUNT-1:0] selectPin,
	output logic                         readPin,
	output logic      [WAIT_W-1:0]       selWait3,
	output logic      [WAIT_W-1:0]       selWait5,
	output logic      [WAIT_W-1:0]       selWait6
);
	logic flip = 1'b0;

	// a floating line with no pull wanders, so it never shows a clean value
	always_ff @(posedge clk_sys) begin
		flip <= ~flip;
	end

	// wired level from driver, weak pull or nothing
	always_comb begin
		for (int i = 0; i < SELECT_COUNT; i++) begin
			selectPin[i] = selectN_oe[i] ? selectN_out[i] :
				(selectWeakPull[i] ? 1'b1 : flip);
		end
		readPin = readN_oe ? readN_out : flip;
	end

	// overlapping selects never wait less than the dram bank
	assign selWait3 = DRAM_WAIT + 4'hA;
	assign selWait5 = DRAM_WAIT + 4'hB;
	assign selWait6 = DRAM_WAIT + 4'hC;
endmodule // bus_side_model
`default_nettype wire

/* periph_pin_pkg.sv */
package periph_pin_pkg;
	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int ADDR_W       = 20;
	localparam int PIO_COUNT    = 32;
	localparam int REGION_SHIFT = 8;   // each select region is 256 bytes
	localparam int SELECT_COUNT = 7;   // selects 0..6, select four unused
	localparam int WAIT_W       = 4;   // wait count incl. extended values
	localparam int NORMAL_WAIT_MAX = 3;

	// pio indices with a pio input default
	localparam int PIO_IDX_SELECT_THREE = 19;
	// power-on defaults: mode bits 1 = pio, 0 = normal function
	localparam logic [31:0] PIO_ENABLE_RESET = 32'hFFFF_FC0F;
	localparam logic [31:0] PIO_DIR_RESET    = 32'hFFFF_FFFF;
	localparam logic [31:0] PIO_PULLUP_RESET = 32'hFFFF_FBFD;
	localparam logic [31:0] PIO_NORMAL_RESET = 32'h0000_03F0;

	// bus cycle phases
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ADDR = 2'b01,
		PH_TURN = 2'b11,
		PH_DATA = 2'b10
	} phase_t;

	// region hit test used for both select decode and dram arbitration
	function automatic logic regionHit(input logic [ADDR_W-1:0] addr,
			input logic [ADDR_W-1:0] base, input int idx);
		logic [ADDR_W-1:0] off;
		off = addr - base;
		return (addr >= base) &&
			(off[ADDR_W-1:REGION_SHIFT] == (ADDR_W-REGION_SHIFT)'(idx));
	endfunction
endpackage

/* periph_select_pin_functions.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - select three pin is a chip select only while port 1 flow control is off
// - each select except four asserts for accesses to its own region of the block
// - every region spans 256 bytes from the programmed base
// - a select hit suppresses an overlapping dram access
// - selects assert with the multiplexed address phase
// - selects float with weak pull during hold; pullup during reset
// - selects three, five, six allow extended wait options
// - send-request asserts while transmit register holds unsent data
// - receive-ready asserts while receive register holds no unread data
// - address-pin mode 0 puts latched address bits on selects five and six
// - latched address bits keep driving during hold
// - 32 pins each configurable: enable, direction, pull
// - most pins default to input with pullup; boot pins normal function
// - read strobe only after bus floated, for read cycles
// - read strobe floats for the whole hold
// - select three pin defaults to pio input with pullup
module periph_select_pin_functions
	import periph_pin_pkg::*;
(
	input  wire logic                     clk_sys,
	input  wire logic                     resetn,
	input  wire logic                     busStart,
	input  wire logic                     busRead,
	input  wire logic [ADDR_W-1:0]        busAddr,
	input  wire logic                     busHold,
	input  wire logic [ADDR_W-1:0]        periphBase,
	input  wire logic                     dramHit,
	input  wire logic [WAIT_W-1:0]        selectWait3,
	input  wire logic [WAIT_W-1:0]        selectWait5,
	input  wire logic [WAIT_W-1:0]        selectWait6,
	input  wire logic                     flow_ctrl_enable,
	input  wire logic                     sendRequestSelect,
	input  wire logic                     address_pin_mode,
	input  wire logic                     txHasData,
	input  wire logic                     rxHasData,
	input  wire logic                     pioCfgWrite,
	input  wire logic [PIO_COUNT-1:0]     pioEnableIn,
	input  wire logic [PIO_COUNT-1:0]     pioDirIn,
	input  wire logic [PIO_COUNT-1:0]     pioPullupIn,
	output logic      [SELECT_COUNT-1:0]  selectN_out,
	output logic      [SELECT_COUNT-1:0]  selectN_oe,
	output logic      [SELECT_COUNT-1:0]  selectWeakPull,
	output logic                          dramEnable,
	output logic      [WAIT_W-1:0]        waitCount,
	output logic                          readN_out,
	output logic                          readN_oe,
	output logic      [PIO_COUNT-1:0]     pioMode,
	output logic      [PIO_COUNT-1:0]     pioInput,
	output logic      [PIO_COUNT-1:0]     pioPullup
);
	import periph_pin_pkg::*;

	// ---------------------------------------------------------------
	// input synchronisers for the asynchronous serial status
	// ---------------------------------------------------------------
	logic [1:0] txSync_r, txSync_nxt, rxSync_r, rxSync_nxt;
	always_comb begin
		txSync_nxt = {txSync_r[0], txHasData};
		rxSync_nxt = {rxSync_r[0], rxHasData};
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			txSync_r <= 2'h0;
			rxSync_r <= 2'h0;
		end else begin
			txSync_r <= txSync_nxt;
			rxSync_r <= rxSync_nxt;
		end
	end

	// ---------------------------------------------------------------
	// bus phase tracking
	// ---------------------------------------------------------------
	phase_t phase_r, phase_nxt;
	logic   isRead_r, isRead_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	// one address phase, one float turn cycle, then data until next start or hold
	always_comb begin
		phase_nxt  = phase_r;
		isRead_nxt = isRead_r;
		addr_nxt   = addr_r;
		unique case (phase_r)
			PH_IDLE,
			PH_DATA: if (busStart && !busHold) begin
				phase_nxt  = PH_ADDR;
				isRead_nxt = busRead;
				addr_nxt   = busAddr;
			end else if (busHold) begin
				phase_nxt = PH_IDLE;
			end
			PH_ADDR: phase_nxt = PH_TURN; // bus floats in PH_TURN, next
			PH_TURN: phase_nxt = PH_DATA;
		endcase
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phase_r  <= PH_IDLE;
			isRead_r <= 1'b0;
			addr_r   <= '0;
		end else begin
			phase_r  <= phase_nxt;
			isRead_r <= isRead_nxt;
			addr_r   <= addr_nxt;
		end
	end

	// ---------------------------------------------------------------
	// region decode and wait limiting
	// ---------------------------------------------------------------
	logic [SELECT_COUNT-1:0] hitVec;
	logic [WAIT_W-1:0] wait3, wait5, wait6;
	always_comb begin
		for (int i = 0; i < SELECT_COUNT; i++)
			hitVec[i] = (i != 4) && regionHit(busAddr, periphBase, i);
	end
	wait_limit #(.EXTENDED(1'b1)) uWait3 (.waitIn(selectWait3), .waitOut(wait3));
	wait_limit #(.EXTENDED(1'b1)) uWait5 (.waitIn(selectWait5), .waitOut(wait5));
	wait_limit #(.EXTENDED(1'b1)) uWait6 (.waitIn(selectWait6), .waitOut(wait6));

	// ---------------------------------------------------------------
	// pio configuration
	// ---------------------------------------------------------------
	logic [PIO_COUNT-1:0] pioModeW, pioInputW, pioPullupW;
	pio_config #(.N(PIO_COUNT)) uPio (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.cfgWrite (pioCfgWrite),
		.enableIn (pioEnableIn),
		.dirIn    (pioDirIn),
		.pullupIn (pioPullupIn),
		.pioMode  (pioModeW),
		.pioInput (pioInputW),
		.pioPullup(pioPullupW)
	);

	// ---------------------------------------------------------------
	// pin outputs
	// ---------------------------------------------------------------
	logic [SELECT_COUNT-1:0] selN_r, selN_nxt, selOe_r, selOe_nxt;
	logic [SELECT_COUNT-1:0] pull_r, pull_nxt;
	logic [1:0] latAddr_r, latAddr_nxt;
	logic dram_r, dram_nxt, rdN_r, rdN_nxt, rdOe_r, rdOe_nxt;
	logic [WAIT_W-1:0] wait_r, wait_nxt;
	logic [PIO_COUNT-1:0] pioM_r, pioI_r, pioP_r;
	// selects latch with the address phase, so the decode uses the
	// raw address in the start cycle rather than the captured copy
	always_comb begin
		selN_nxt    = selN_r;
		latAddr_nxt = latAddr_r;
		dram_nxt    = dram_r;
		wait_nxt    = wait_r;
		if (busStart && !busHold) begin
			selN_nxt    = ~hitVec;
			latAddr_nxt = busAddr[2:1];
			dram_nxt    = dramHit && (hitVec == '0);
			wait_nxt    = hitVec[3] ? wait3 : hitVec[5] ? wait5 :
				hitVec[6] ? wait6 : '0;
		end else if (phase_nxt == PH_IDLE) begin
			selN_nxt = '1;
			dram_nxt = 1'b0;
		end
		// shared select-three pin carries flow control when enabled
		if (flow_ctrl_enable)
			selN_nxt[3] = sendRequestSelect ? ~txSync_r[1]
				: rxSync_r[1];
		if (!address_pin_mode) begin
			selN_nxt[5] = latAddr_nxt[0];
			selN_nxt[6] = latAddr_nxt[1];
		end
		// hold floats selects; latched address pins keep driving
		// each select pin drives only when its pio slot is normal function, unless it carries latched address bits
		selOe_nxt = '0;
		if (!busHold) begin
			selOe_nxt[0] = !pioModeW[16];
			selOe_nxt[1] = !pioModeW[17];
			selOe_nxt[2] = !pioModeW[18];
			selOe_nxt[3] = !pioModeW[PIO_IDX_SELECT_THREE];
			selOe_nxt[5] = !pioModeW[3];
			selOe_nxt[6] = !pioModeW[2];
		end
		if (!address_pin_mode) begin
			selOe_nxt[5] = 1'b1;
			selOe_nxt[6] = 1'b1;
		end
		pull_nxt = busHold ? ~selOe_nxt : '0;
		// strobe only in data phase of a read, after the turn cycle
		rdN_nxt  = !(isRead_r && phase_nxt == PH_DATA && !busHold);
		rdOe_nxt = !busHold;
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			selN_r    <= '1;
			selOe_r   <= '0; // pulled up during reset
			pull_r    <= '1;
			latAddr_r <= 2'h0;
			dram_r    <= 1'b0;
			wait_r    <= '0;
			rdN_r     <= 1'b1;
			rdOe_r    <= 1'b0;
			pioM_r    <= PIO_ENABLE_RESET;
			pioI_r    <= PIO_DIR_RESET;
			pioP_r    <= PIO_PULLUP_RESET;
		end else begin
			selN_r    <= selN_nxt;
			selOe_r   <= selOe_nxt;
			pull_r    <= pull_nxt;
			latAddr_r <= latAddr_nxt;
			dram_r    <= dram_nxt;
			wait_r    <= wait_nxt;
			rdN_r     <= rdN_nxt;
			rdOe_r    <= rdOe_nxt;
			pioM_r    <= pioModeW;
			pioI_r    <= pioInputW;
			pioP_r    <= pioPullupW;
		end
	end
	assign selectN_out    = selN_r;
	assign selectN_oe     = selOe_r;
	assign selectWeakPull = pull_r;
	assign dramEnable     = dram_r;
	assign waitCount      = wait_r;
	assign readN_out      = rdN_r;
	assign readN_oe       = rdOe_r;
	assign pioMode        = pioM_r;
	assign pioInput       = pioI_r;
	assign pioPullup      = pioP_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// every check below runs on the system clock and sleeps in reset
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	// dram arbitration and select timing
	a_dram_suppressed: assert property (
		(busStart && !busHold && hitVec != '0) |=> !dramEnable)
		else $error("dram enabled alongside a select hit");
	a_dram_alone: assert property (
		(busStart && !busHold && dramHit && hitVec == '0) |=> dramEnable)
		else $error("dram access dropped without a select hit");
	a_sel_with_addr: assert property (
		(busStart && !busHold && hitVec[0]) |=> !selectN_out[0])
		else $error("select zero missed address phase");
	a_sel_three_cs: assert property (
		(!flow_ctrl_enable && busStart && !busHold && hitVec[3])
		|=> !selectN_out[3])
		else $error("select three missed with flow control off");
	a_select_four_idle: assert property (
		selectN_out[4])
		else $error("unused select four asserted");

	// extended wait counts pass through unclipped
	a_wait_three: assert property (
		(busStart && !busHold && hitVec[3]) |=> waitCount == $past(selectWait3))
		else $error("select three wait count wrong");
	a_wait_five: assert property (
		(busStart && !busHold && hitVec[5]) |=> waitCount == $past(selectWait5))
		else $error("select five wait count wrong");
	a_wait_six: assert property (
		(busStart && !busHold && hitVec[6]) |=> waitCount == $past(selectWait6))
		else $error("select six wait count wrong");

	// hold behaviour of selects and strobe
	a_hold_float: assert property (
		busHold |=> (selectN_oe[0] == 1'b0) && selectWeakPull[0])
		else $error("select driven during hold");
	a_oe_off_hold: assert property (
		(busHold && address_pin_mode) |=> selectN_oe == '0)
		else $error("a select pin driven during hold");
	a_rd_float: assert property (
		busHold |=> !readN_oe)
		else $error("read strobe driven during hold");
	a_rd_high_hold: assert property (
		busHold |=> readN_out)
		else $error("read strobe active during hold");

	// read strobe only after the turn cycle, and only for reads
	a_rd_after_turn: assert property (
		(busStart && !busHold) |=> readN_out ##1 readN_out)
		else $error("read strobe before bus float");
	a_rd_only_reads: assert property (
		(busStart && !busHold && !busRead) |=> readN_out [*3])
		else $error("read strobe during a write");
	a_rd_strobe_data: assert property (
		(busStart && !busHold && busRead) ##2 !busHold |=> !readN_out)
		else $error("read strobe missing in data phase");

	// latched address pins
	a_addr_bits: assert property (
		(!address_pin_mode && busStart && !busHold)
		|=> selectN_out[6:5] == $past(busAddr[2:1]))
		else $error("latched address bits wrong");
	a_addr_bits_hold: assert property (
		(busHold && !address_pin_mode && $past(!address_pin_mode))
		|=> $stable(selectN_out[6:5]))
		else $error("latched address bits moved in hold");
	a_addr_pins_hold: assert property (
		(busHold && !address_pin_mode) |=> selectN_oe[5] && selectN_oe[6])
		else $error("latched address pin floated in hold");

	// flow-control outputs on the shared pin
	a_send_request: assert property (
		(flow_ctrl_enable && sendRequestSelect && txSync_r[1])
		|=> !selectN_out[3])
		else $error("send request not asserted");
	a_receive_ready: assert property (
		(flow_ctrl_enable && !sendRequestSelect && !rxSync_r[1])
		|=> !selectN_out[3])
		else $error("receive ready not asserted");
endmodule // periph_select_pin_functions
`default_nettype wire

/* pio_config.sv */
`timescale 1ns/1ps
`default_nettype none
// per-pin programmable io configuration with power-on defaults
module pio_config #(
	parameter int N = periph_pin_pkg::PIO_COUNT
) (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic         cfgWrite,
	input  wire logic [N-1:0] enableIn,
	input  wire logic [N-1:0] dirIn,
	input  wire logic [N-1:0] pullupIn,
	output logic      [N-1:0] pioMode,
	output logic      [N-1:0] pioInput,
	output logic      [N-1:0] pioPullup
);
	import periph_pin_pkg::*;
	logic [N-1:0] mode_r, mode_nxt, dir_r, dir_nxt, pull_r, pull_nxt;
	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_comb begin
		mode_nxt = mode_r;
		dir_nxt  = dir_r;
		pull_nxt = pull_r;
		if (cfgWrite) begin
			// stored as a pio flag, so a 1 written means normal function
			mode_nxt = ~enableIn;
			dir_nxt  = dirIn;
			pull_nxt = pullupIn;
		end
	end
	// defaults: mostly inputs with pullup, boot pins normal function
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_r <= N'(PIO_ENABLE_RESET);
			dir_r  <= N'(PIO_DIR_RESET);
			pull_r <= N'(PIO_PULLUP_RESET);
		end else begin
			mode_r <= mode_nxt;
			dir_r  <= dir_nxt;
			pull_r <= pull_nxt;
		end
	end
	// every pin stays individually programmable, boot pins included
	assign pioMode   = mode_r;
	assign pioInput  = dir_r;
	assign pioPullup = pull_r;
endmodule // pio_config
`default_nettype wire

/* test_periph_select_pin_functions.sv */
`timescale 1ns/1ps
`default_nettype none
module test_periph_select_pin_functions;
	import periph_pin_pkg::*;
	localparam logic [ADDR_W-1:0] BASE = 20'h04000;
	logic                    clk_sys = 1'b0;
	logic                    resetn = 1'b0;
	logic                    busStart = 1'b0;
	logic                    busRead = 1'b0;
	logic                    busHold = 1'b0;
	logic                    dramHit = 1'b0;
	logic                    flowOn = 1'b0;
	logic                    sendSel = 1'b0;
	logic                    addrMode = 1'b1;
	logic                    txHas = 1'b0;
	logic                    rxHas = 1'b1;
	logic                    cfgWr = 1'b0;
	logic [ADDR_W-1:0]       busAddr = '0;
	logic [31:0]             enIn = '0;
	logic [31:0]             dirIn = '0;
	logic [31:0]             pullIn = '0;
	logic [SELECT_COUNT-1:0] selN, selOe, selPull, selPin;
	logic                    dramEn, rdN, rdOe, rdPin;
	logic [WAIT_W-1:0]       wCnt, w3, w5, w6;
	logic [31:0]             pMode, pIn, pPull;
	int                      miscompares = 0;
	int                      checkCount = 0;

	// clock, 25 ns period
	always #12.5 clk_sys = ~clk_sys;

	periph_select_pin_functions u_periph_select_pin_functions (
		.clk_sys(clk_sys), .resetn(resetn), .busStart(busStart),
		.busRead(busRead), .busAddr(busAddr), .busHold(busHold),
		.periphBase(BASE), .dramHit(dramHit), .selectWait3(w3),
		.selectWait5(w5), .selectWait6(w6), .flow_ctrl_enable(flowOn),
		.sendRequestSelect(sendSel), .address_pin_mode(addrMode),
		.txHasData(txHas), .rxHasData(rxHas), .pioCfgWrite(cfgWr),
		.pioEnableIn(enIn), .pioDirIn(dirIn), .pioPullupIn(pullIn),
		.selectN_out(selN), .selectN_oe(selOe), .selectWeakPull(selPull),
		.dramEnable(dramEn), .waitCount(wCnt), .readN_out(rdN),
		.readN_oe(rdOe), .pioMode(pMode), .pioInput(pIn),
		.pioPullup(pPull));

	bus_side_model u_bus_side_model (
		.clk_sys(clk_sys), .selectN_out(selN), .selectN_oe(selOe),
		.selectWeakPull(selPull), .readN_out(rdN), .readN_oe(rdOe),
		.selectPin(selPin), .readPin(rdPin), .selWait3(w3),
		.selWait5(w5), .selWait6(w6));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
			input string what);
		checkCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s seen %h want %h", $time, what,
				seen, exp);
		end
	endtask

	// inputs move 2 ns after the edge, outputs are settled by then
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask

	task automatic access(input logic [ADDR_W-1:0] a, input logic rd,
			input logic dh);
		busAddr = a;
		busRead = rd;
		dramHit = dh;
		busStart = 1'b1;
		tick(1);
		busStart = 1'b0;
		tick(1);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic testReset();
		check(32'({selN, selOe, selPull}), 32'h1FC07F, "rst sel");
		check(32'({rdOe, selPin}), 32'h7F, "rst pins");
	endtask

	// boot pins normal, pulldowns on two timer pins, then reprogram
	task automatic testPio();
		check(pMode, 32'hFFFFFC0F, "pio mode");
		check(pIn & pPull, 32'hFFFFFBFD, "pio in/pull");
		// strobe pins 15, 24, 25 back to normal before any dram use
		enIn = 32'h0300FFFF;
		dirIn = 32'hA5A5A5A5;
		pullIn = 32'h3C3C3C3C;
		cfgWr = 1'b1;
		tick(1);
		cfgWr = 1'b0;
		tick(1);
		check(pMode, 32'hFCFF0000, "pio cfg mode");
		check(pIn ^ pPull, 32'h99999999, "pio cfg dir");
	endtask

	// each region except four at one end (even at the start, odd at the top); beyond region six and below base, none
	task automatic testDecode();
		logic [6:0] exp;
		for (int i = -1; i < 8; i++) begin
			if (i == 4) continue;
			access(BASE + 20'(i * 256 + ((i & 1) ? 255 : 0)), 1'b0, 1'b0);
			exp = (i >= 0 && i < 7) ? ~(7'h01 << i) : 7'h7F;
			check(32'(selN), 32'(exp), "region");
		end
	endtask

	task automatic testDram();
		access(BASE + 20'h300, 1'b0, 1'b1);
		check(32'({dramEn, wCnt}), 32'h0C, "dram s3");
		access(BASE + 20'h5FF, 1'b0, 1'b1);
		check(32'({dramEn, wCnt}), 32'h0D, "dram s5");
		access(BASE + 20'h600, 1'b0, 1'b1);
		check(32'({dramEn, wCnt}), 32'h0E, "dram s6");
		access(20'h10000, 1'b0, 1'b1);
		check(32'(dramEn), 32'h1, "dram alone");
	endtask

	// strobe waits for the turn cycle; writes never strobe
	task automatic testRead();
		access(BASE + 20'h10, 1'b1, 1'b0);
		check(32'(rdN), 32'h1, "read early");
		tick(2);
		check(32'({rdOe, rdPin}), 32'h2, "read strobe");
		access(BASE + 20'h10, 1'b0, 1'b0);
		tick(2);
		check(32'(rdPin), 32'h1, "write strobe");
	endtask

	task automatic testHold();
		addrMode = 1'b0;
		access(20'h00002, 1'b1, 1'b0);
		check(32'(selN[6:5]), 32'h1, "addr bits");
		busHold = 1'b1;
		tick(2);
		access(20'h00004, 1'b0, 1'b0);
		check(32'({selOe, selN[6:5]}), 32'h181, "hold keep");
		check(32'({rdOe, selPin[3:0]}), 32'hF, "hold float");
		busHold = 1'b0;
		addrMode = 1'b1;
		tick(2);
	endtask

	// status inputs pass two sync flops, so allow four cycles
	task automatic testFlow();
		flowOn = 1'b1;
		sendSel = 1'b1;
		txHas = 1'b1;
		tick(4);
		check(32'(selN[3]), 32'h0, "send req");
		txHas = 1'b0;
		sendSel = 1'b0;
		tick(4);
		check(32'(selN[3]), 32'h1, "rx full");
		access(BASE + 20'h300, 1'b0, 1'b0);
		check(32'(selN[3]), 32'h1, "no select");
		rxHas = 1'b0;
		tick(4);
		check(32'(selN[3]), 32'h0, "rx ready");
		flowOn = 1'b0;
	endtask

	// main sequence, reset held five cycles
	initial begin
		tick(2);
		testReset();
		tick(3);
		resetn = 1'b1;
		tick(1);
		testPio();
		testDecode();
		testDram();
		testRead();
		testHold();
		testFlow();
		complete_run();
	end

	// watchdog, well beyond the roughly 60 cycles the run needs
	initial begin
		#100000;
		miscompares++;
		complete_run();
	end
endmodule // test_periph_select_pin_functions
`default_nettype wire

/* wait_limit.sv */
`timescale 1ns/1ps
`default_nettype none
// clamps a select wait count to the range that select supports
module wait_limit #(
	parameter bit EXTENDED = 1'b0
) (
	input  wire logic [periph_pin_pkg::WAIT_W-1:0] waitIn,
	output logic      [periph_pin_pkg::WAIT_W-1:0] waitOut
);
	import periph_pin_pkg::*;
	// ---------------------------------------------------------------
	// clamp
	// ---------------------------------------------------------------
	always_comb begin
		if (EXTENDED || waitIn <= WAIT_W'(NORMAL_WAIT_MAX))
			waitOut = waitIn;
		else
			waitOut = WAIT_W'(NORMAL_WAIT_MAX);
	end
endmodule // wait_limit
`default_nettype wire
